// ==== bench/tb_option_wdt_carrier_config.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_option_wdt_carrier_config;
    logic       sys_clk_in, rst_b_in, wdt_enable_in, wdt_two_clear_in, halted_in;
    logic       restart_cmd_in, restart_first_half_in, restart_second_half_in;
    logic [1:0] wdt_exp_sel_in, carrier_n_in;
    logic [5:0] wake_capable_port_in, wake_enable_mask_in;
    logic       carrier_mode_in, shared_out_latch_bit_in, carrier_m3_in;
    logic       carrier_third_duty_in, lvr_enable_in, low_supply_in;
    wire logic  instr_tick_out, carrier_out, wdt_reset_out, wake_out, low_supply_reset_out;
    int         miscompares = 0;
    int         cmp_count = 0;
    int         wdt_seen = 0;

    // short lvr window keeps the run brief
    owc_core #(.LVR_CYCLES(8)) u_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .wdt_exp_sel_in(wdt_exp_sel_in), .wdt_enable_in(wdt_enable_in),
        .wdt_two_clear_in(wdt_two_clear_in), .restart_cmd_in(restart_cmd_in),
        .restart_first_half_in(restart_first_half_in),
        .restart_second_half_in(restart_second_half_in), .halted_in(halted_in),
        .wake_capable_port_in(wake_capable_port_in), .wake_enable_mask_in(wake_enable_mask_in),
        .carrier_mode_in(carrier_mode_in), .shared_out_latch_bit_in(shared_out_latch_bit_in),
        .carrier_m3_in(carrier_m3_in), .carrier_n_in(carrier_n_in),
        .carrier_third_duty_in(carrier_third_duty_in), .lvr_enable_in(lvr_enable_in),
        .low_supply_in(low_supply_in), .instr_tick_out(instr_tick_out),
        .carrier_out(carrier_out), .wdt_reset_out(wdt_reset_out), .wake_out(wake_out),
        .low_supply_reset_out(low_supply_reset_out));

    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) if (wdt_reset_out === 1'b1) wdt_seen++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : chk
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic clks(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : clks
    // 0 single, 1 first half, 2 second half, 3 both halves
    task automatic pulse(input int k);
        restart_cmd_in = (k == 0);
        restart_first_half_in = (k == 1 || k == 3);
        restart_second_half_in = (k >= 2);
        clks(1);
        {restart_cmd_in, restart_first_half_in, restart_second_half_in} = 3'h0;
    endtask : pulse
    // clocks until watchdog pulse (sel 0) or wake (sel 1); edges may jitter by up to six clocks
    task automatic near(input int sel, input int exp, input string what);
        int c;
        c = 0;
        while (c < 9000) begin
            @(posedge sys_clk_in);
            #1;
            c++;
            if (sel == 0 ? wdt_reset_out === 1'b1 : wake_out === 1'b1) break;
        end
        @(negedge sys_clk_in);
        chk(c >= exp - 6 && c <= exp + 6, 1, what);
    endtask : near
    task automatic run_len(input logic v, input int lim, output int n);
        n = 0;
        while (carrier_out === v && n < lim) begin
            clks(1);
            n++;
        end
    endtask : run_len

    task automatic t_tick;
        int n;
        n = 0;
        repeat (8) begin @(posedge sys_clk_in); #1; if (instr_tick_out === 1'b1) break; end
        repeat (8) begin @(posedge sys_clk_in); #1; n++; if (instr_tick_out === 1'b1) break; end
        clks(1);
        chk(n, 4, "instr_period");
    endtask : t_tick
    task automatic t_wdt;
        int w;
        for (int n = 0; n < 4; n++) begin
            wdt_exp_sel_in = n[1:0];
            pulse(0);
            near(0, 4 << (n + 8), "wdt_period");
        end
        wdt_exp_sel_in = 2'h0;
        pulse(0);
        clks(500);
        pulse(0);
        near(0, 1024, "single_clear");
        wdt_two_clear_in = 1'b1;
        pulse(3);
        clks(500);
        pulse(2);
        clks(300);
        near(0, 1024 - 801, "half_alone");
        pulse(2);
        clks(500);
        pulse(0);
        clks(300);
        pulse(1);
        near(0, 1024, "pair_clear");
        clks(400);
        pulse(1);
        near(0, 1024 - 401, "half_forget");
        wdt_two_clear_in = 1'b0;
        halted_in = 1'b1;
        pulse(0);
        w = wdt_seen;
        near(1, 1024, "halt_wake");
        clks(2);
        chk(wdt_seen - w, 0, "halt_no_reset");
        wdt_enable_in = 1'b0;
        w = wdt_seen;
        clks(1200);
        chk(wdt_seen - w, 0, "wdt_off");
        wake_enable_mask_in = 6'h01;
        wake_capable_port_in = 6'h3d;
        clks(6);
        chk(wake_out, 0, "unmasked_pin");
        wake_capable_port_in = 6'h3e;
        clks(4);
        chk(wake_out, 1, "masked_pin");
        wake_capable_port_in = 6'h3f;
        {halted_in, wdt_enable_in} = 2'h1;
    endtask : t_wdt
    task automatic t_carrier;
        int x, hi, lo, per, hit;
        shared_out_latch_bit_in = 1'b0;
        for (int i = 0; i < 16; i++) begin
            {carrier_m3_in, carrier_n_in, carrier_third_duty_in} = i[3:0];
            per = (i[3] ? 3 : 2) << i[2:1];
            hit = !i[3] ? 1 << i[2:1] : i[2:1] == 0 ? 1 : i[0] ? 1 << i[2:1] : 3 << (i[2:1] - 1);
            clks(100);
            run_len(1'b1, 200, x);
            run_len(1'b0, 200, x);
            run_len(1'b1, 200, hi);
            run_len(1'b0, 200, lo);
            chk(hi, 4 * hit, "carrier_high");
            chk(hi + lo, 4 * per, "carrier_period");
        end
        shared_out_latch_bit_in = 1'b1;
        clks(3);
        run_len(1'b0, 100, x);
        chk(x, 100, "carrier_stopped_low");
        carrier_mode_in = 1'b0;
        clks(3);
        chk(carrier_out, 1, "level_high");
        shared_out_latch_bit_in = 1'b0;
        clks(3);
        chk(carrier_out, 0, "level_low");
    endtask : t_carrier
    task automatic t_lvr;
        {lvr_enable_in, low_supply_in} = 2'h3;
        clks(4);
        low_supply_in = 1'b0;
        clks(4);
        chk(low_supply_reset_out, 0, "short_dip");
        low_supply_in = 1'b1;
        clks(16);
        chk(low_supply_reset_out, 1, "long_dip");
        {lvr_enable_in, low_supply_in} = 2'h1;
        clks(16);
        chk(low_supply_reset_out, 0, "lvr_off");
    endtask : t_lvr

    initial begin
        {rst_b_in, wdt_two_clear_in, halted_in, restart_cmd_in} = 4'h0;
        {restart_first_half_in, restart_second_half_in, carrier_m3_in} = 3'h0;
        {carrier_third_duty_in, lvr_enable_in, low_supply_in} = 3'h0;
        {wdt_exp_sel_in, carrier_n_in, wake_enable_mask_in} = 10'h000;
        {wdt_enable_in, carrier_mode_in, shared_out_latch_bit_in} = 3'h7;
        wake_capable_port_in = 6'h3f;
        clks(5);
        chk({instr_tick_out, carrier_out, wdt_reset_out, wake_out, low_supply_reset_out},
            0, "reset_outputs");
        rst_b_in = 1'b1;
        clks(2);
        t_tick();
        t_wdt();
        t_carrier();
        t_lvr();
        complete_run();
    end
    initial begin
        #1200000;
        miscompares++;
        complete_run();
    end
endmodule : tb_option_wdt_carrier_config
`default_nettype wire

// ==== pkg/owc_pkg.sv ====
package owc_pkg;
    // instruction clock is the system clock divided by four
    localparam int unsigned SYS_CLK_MHZ     = 50;
    localparam int unsigned INSTR_DIV       = 4;
    localparam logic [1:0]  INSTR_LAST      = 2'h3;
    // watchdog exponent range
    localparam int unsigned WDT_EXP_MIN     = 8;
    localparam int unsigned WDT_EXP_MAX     = 11;
    localparam int unsigned WDT_W           = 12;
    localparam logic [1:0]  WDT_SEL_RST     = 2'h0;
    // carrier divider: m times 2^n, m = 2 or 3, n = 0..3
    localparam int unsigned CAR_W           = 5;
    localparam logic [4:0]  CAR_CNT_RST     = 5'h00;
    localparam logic [4:0]  CAR_ONE         = 5'h01;
    localparam logic [4:0]  CAR_M2          = 5'h02;
    localparam logic [4:0]  CAR_M3          = 5'h03;
    localparam int unsigned CAR_N_MAX       = 3;
    // low supply must persist this long before reset
    localparam int unsigned LVR_TIME_US     = 1000;
    localparam int unsigned LVR_CYCLES      = LVR_TIME_US * SYS_CLK_MHZ;
    localparam int unsigned LVR_W           = 16;
endpackage : owc_pkg

// ==== src/owc_core.sv ====
//
// Contract
// - watchdog times out after 2^n instruction clocks, n chosen 8 to 11
// - watchdog disable option holds the counter at zero; no time-out ever
// - single-clear policy: one restart command clears the counter at once
// - two-clear policy: counter clears only after both halves executed
// - only port bits marked wake-capable, or a watchdog time-out, may wake the halted device
// - option routes shared pin to carrier or to the plain latch level
// - divide by 2,4,8,16 gives half duty square wave
// - divide by 3 gives output high one third of the period
// - divide by 6,12,24 lets an option pick half or third duty
// - low supply reset option; disabled means supply dips never reset
// - instruction cycle is exactly four system clocks and feeds the carrier
// - carrier source is the instruction clock; ratio m times 2^n
// - in carrier mode latch zero runs carrier, latch one holds pin low
// - carrier output is low after any chip reset
`timescale 1ns/10ps
`default_nettype none
module owc_core #(
    parameter int unsigned LVR_CYCLES = owc_pkg::LVR_CYCLES
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic [1:0] wdt_exp_sel_in,
    input  wire logic       wdt_enable_in,
    input  wire logic       wdt_two_clear_in,
    input  wire logic       restart_cmd_in,
    input  wire logic       restart_first_half_in,
    input  wire logic       restart_second_half_in,
    input  wire logic       halted_in,
    input  wire logic [5:0] wake_capable_port_in,
    input  wire logic [5:0] wake_enable_mask_in,
    input  wire logic       carrier_mode_in,
    input  wire logic       shared_out_latch_bit_in,
    input  wire logic       carrier_m3_in,
    input  wire logic [1:0] carrier_n_in,
    input  wire logic       carrier_third_duty_in,
    input  wire logic       lvr_enable_in,
    input  wire logic       low_supply_in,
    output var  logic       instr_tick_out,
    output var  logic       carrier_out,
    output var  logic       wdt_reset_out,
    output var  logic       wake_out,
    output var  logic       low_supply_reset_out
);
    // pin inputs pass two flops first
    logic [5:0] wake_s1_q, wake_s2_q;
    logic       low_s1_q, low_s2_q;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wake_s1_q <= '1;
            wake_s2_q <= '1;
            low_s1_q  <= 1'b0;
            low_s2_q  <= 1'b0;
        end else begin
            wake_s1_q <= wake_capable_port_in;
            wake_s2_q <= wake_s1_q;
            low_s1_q  <= low_supply_in;
            low_s2_q  <= low_s1_q;
        end
    end

    // instruction clock divider
    logic [1:0] phase_q, phase_d;
    logic       tick_d;
    always_comb begin
        phase_d = phase_q + 2'h1;
        tick_d  = (phase_q == owc_pkg::INSTR_LAST);
    end

    // watchdog
    typedef enum logic [1:0] {OWC_HALF_NONE, OWC_HALF_FIRST, OWC_HALF_SECOND} owc_half_e;
    logic [11:0] wdt_cnt_q, wdt_cnt_d;
    owc_half_e   half_q, half_d;
    logic        wdt_rst_d, wake_d;
    logic        do_clear;
    logic [11:0] wdt_limit;

    function automatic logic [11:0] owc_pow2(input logic [1:0] sel);
        owc_pow2 = 12'h001 << (owc_pkg::WDT_EXP_MIN + sel); // 2^(8+sel)
    endfunction : owc_pow2

    always_comb begin
        wdt_limit = owc_pow2(wdt_exp_sel_in);
        half_d    = half_q;
        do_clear  = 1'b0;
        if (!wdt_two_clear_in) begin
            do_clear = restart_cmd_in;
            half_d   = OWC_HALF_NONE;
        end else begin
            unique case (half_q)
                OWC_HALF_NONE: begin
                    if (restart_first_half_in && restart_second_half_in) do_clear = 1'b1;
                    else if (restart_first_half_in) half_d = OWC_HALF_FIRST;
                    else if (restart_second_half_in) half_d = OWC_HALF_SECOND;
                end
                OWC_HALF_FIRST: begin
                    do_clear = restart_second_half_in;
                end
                OWC_HALF_SECOND: begin
                    do_clear = restart_first_half_in;
                end
                default: half_d = OWC_HALF_NONE;
            endcase
            if (do_clear) half_d = OWC_HALF_NONE;
        end
        wdt_cnt_d = wdt_cnt_q;
        wdt_rst_d = 1'b0;
        wake_d    = halted_in && |(~wake_s2_q & wake_enable_mask_in);
        if (!wdt_enable_in) begin
            wdt_cnt_d = '0;
        end else if (do_clear) begin
            wdt_cnt_d = '0;
        end else if (tick_d) begin
            if (wdt_cnt_q + 12'h001 >= wdt_limit) begin
                wdt_cnt_d = '0;
                if (halted_in) wake_d = 1'b1;
                else wdt_rst_d = 1'b1;
            end else begin
                wdt_cnt_d = wdt_cnt_q + 12'h001;
            end
        end
    end

    // carrier: count instruction ticks over m*2^n
    logic [4:0] car_cnt_q, car_cnt_d;
    logic [4:0] car_period, car_high;
    logic       car_d;
    always_comb begin
        car_period = (carrier_m3_in ? owc_pkg::CAR_M3 : owc_pkg::CAR_M2) << carrier_n_in;
        if (!carrier_m3_in) car_high = car_period >> 1;
        else if (carrier_n_in == 2'h0) car_high = owc_pkg::CAR_ONE;
        else if (carrier_third_duty_in) car_high = 5'h01 << carrier_n_in;
        else car_high = car_period >> 1;
        car_cnt_d = car_cnt_q;
        if (!carrier_mode_in || shared_out_latch_bit_in) car_cnt_d = owc_pkg::CAR_CNT_RST;
        else if (tick_d) car_cnt_d = (car_cnt_q + owc_pkg::CAR_ONE >= car_period)
                                   ? owc_pkg::CAR_CNT_RST : car_cnt_q + owc_pkg::CAR_ONE;
        if (carrier_mode_in)
            car_d = !shared_out_latch_bit_in && (car_cnt_d < car_high);
        else
            car_d = shared_out_latch_bit_in;
    end

    // low supply filter; short dips are ignored
    logic [15:0] lvr_cnt_q, lvr_cnt_d;
    logic        lvr_d;
    always_comb begin
        lvr_cnt_d = lvr_cnt_q;
        lvr_d     = 1'b0;
        if (!lvr_enable_in || !low_s2_q) lvr_cnt_d = '0;
        else if (lvr_cnt_q >= LVR_CYCLES[15:0] - 16'h0001) lvr_d = 1'b1;
        else lvr_cnt_d = lvr_cnt_q + 16'h0001;
    end

    owc_half_e half_r;
    assign half_r = half_q;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_q              <= 2'h0;
            instr_tick_out       <= 1'b0;
            wdt_cnt_q            <= '0;
            half_q               <= OWC_HALF_NONE;
            wdt_reset_out        <= 1'b0;
            wake_out             <= 1'b0;
            car_cnt_q            <= owc_pkg::CAR_CNT_RST;
            carrier_out          <= 1'b0;
            lvr_cnt_q            <= '0;
            low_supply_reset_out <= 1'b0;
        end else begin
            phase_q              <= phase_d;
            instr_tick_out       <= tick_d;
            wdt_cnt_q            <= wdt_cnt_d;
            half_q               <= half_d;
            wdt_reset_out        <= wdt_rst_d;
            wake_out             <= wake_d;
            car_cnt_q            <= car_cnt_d;
            carrier_out          <= car_d;
            lvr_cnt_q            <= lvr_cnt_d;
            low_supply_reset_out <= lvr_d;
        end
    end

    property p_tick_period;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        instr_tick_out |=> !instr_tick_out [*3] ##1 instr_tick_out;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick not every 4 clocks");

    property p_wdt_off;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        !wdt_enable_in |=> !wdt_reset_out;
    endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("timeout while disabled");

    property p_single_clear;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (wdt_enable_in && !wdt_two_clear_in && restart_cmd_in) |=> wdt_cnt_q == '0;
    endproperty
    a_single_clear: assert property (p_single_clear) else $error("restart did not clear");

    property p_two_clear;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (wdt_two_clear_in && half_r == OWC_HALF_NONE && restart_first_half_in
         && !restart_second_half_in && wdt_enable_in && wdt_cnt_q > 12'h001
         && (wdt_cnt_q + 12'h001 < wdt_limit))
        |=> wdt_cnt_q != '0;
    endproperty
    a_two_clear: assert property (p_two_clear) else $error("cleared on one half");

    property p_half_forget;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (wdt_two_clear_in && do_clear) |=> half_q == OWC_HALF_NONE;
    endproperty
    a_half_forget: assert property (p_half_forget) else $error("half record kept");

    property p_wake_gate;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!halted_in) |=> !wake_out;
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake while running");

    property p_latch_low;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (carrier_mode_in && shared_out_latch_bit_in) |=> !carrier_out;
    endproperty
    a_latch_low: assert property (p_latch_low) else $error("carrier not held low");

    property p_level_mode;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        !carrier_mode_in |=> carrier_out == $past(shared_out_latch_bit_in);
    endproperty
    a_level_mode: assert property (p_level_mode) else $error("level mode mismatch");

    property p_lvr_off;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        !lvr_enable_in |=> !low_supply_reset_out;
    endproperty
    a_lvr_off: assert property (p_lvr_off) else $error("reset with option off");

    property p_wdt_bound;
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        wdt_cnt_q < owc_pow2(wdt_exp_sel_in);
    endproperty
    a_wdt_bound: assert property (p_wdt_bound) else $error("counter past limit");

    c_wdt_reset: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) wdt_reset_out);
    c_wake: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) wake_out);
    c_carrier: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) $rose(carrier_out));
    c_lvr: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) low_supply_reset_out);
endmodule : owc_core
`default_nettype wire
